// ### hdl/tlpma_regs.sv
// Management register slice of a single-pair 10 Mb/s PMA, AXI4-Lite slave.
// Assumes link indications and MSE value arrive synchronous to CLK_SYS.
`timescale 1ns/10ps
module tlpma_regs (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [tlpma_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [tlpma_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic HIGH_LEVEL_TX_STRAP,
    input wire logic REMOTE_RECEIVER_OK,
    input wire logic LOCAL_RECEIVER_OK,
    input wire logic DESCRAMBLER_OK,
    input wire logic LINK_OK,
    input wire logic [15:0] MSE_IN,
    output logic TX_TEST_OVERRIDE,
    output logic [1:0] TX_TEST_SYMBOL,
    output logic TX_FORCE_MASTER,
    output logic [10:0] CR_OFFSET_THRESHOLD,
    output logic [15:0] ECHO_ACQ_GAIN
);
    import tlpma_pkg::*;

    function automatic logic [15:0] word_index(input logic [ADDR_W-1:0] addr);
        word_index = addr[ADDR_W-1:2];
    endfunction : word_index

    // Reset release through two flops
    logic rst_meta;
    logic rst_sync_n;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Strap caught after reset release, not under the async reset
    logic high_level_tx_ability;
    logic strap_taken;
    always_ff @(posedge CLK_SYS or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            strap_taken <= 1'b0;
            high_level_tx_ability <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            high_level_tx_ability <= HIGH_LEVEL_TX_STRAP;
        end
    end

    // Control registers and the registered MSE value
    logic [2:0] tx_test_pattern_select;
    logic [10:0] cr_threshold;
    logic [15:0] echo_gain;
    logic [15:0] mse_value;

    // Latch-low flags, index order: link, descrambler, local, remote
    logic [3:0] latched_low;
    logic [3:0] live_ok;
    logic [3:0] live_seen;
    assign live_ok = {REMOTE_RECEIVER_OK, LOCAL_RECEIVER_OK, DESCRAMBLER_OK, LINK_OK};

    // Write channel: address and data taken in either order
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_fire = S_AXI_AWVALID & S_AXI_AWREADY;
    wire w_fire = S_AXI_WVALID & S_AXI_WREADY;
    wire have_aw = aw_held | aw_fire;
    wire have_w = w_held | w_fire;
    wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr : S_AXI_AWADDR;
    wire [31:0] wr_data = w_held ? w_data : S_AXI_WDATA;
    wire [3:0] wr_strb = w_held ? w_strb : S_AXI_WSTRB;
    wire do_write = have_aw & have_w & ~S_AXI_BVALID;
    wire [15:0] wr_idx = word_index(wr_addr);
    wire [15:0] wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire wr_test = do_write & (wr_idx == IDX_TEST_MODE);
    wire wr_thr = do_write & (wr_idx == IDX_CR_THRESHOLD);
    wire wr_gain = do_write & (wr_idx == IDX_ECHO_GAIN);
    // Read-only words accept a write silently; unmapped answers SLVERR
    wire wr_known = (wr_idx == IDX_TEST_MODE) | (wr_idx == IDX_CR_THRESHOLD) | (wr_idx == IDX_ECHO_GAIN)
        | (wr_idx == IDX_ABILITY) | (wr_idx == IDX_LINK_STATUS) | (wr_idx == IDX_MSE)
        | (wr_idx == IDX_TEST_STATE);
    wire [15:0] test_word = {tx_test_pattern_select, 13'h0000};
    wire [15:0] next_test_word = (wr_data[15:0] & wr_mask) | (test_word & ~wr_mask);
    wire [15:0] thr_word = {5'h00, cr_threshold};
    wire [15:0] next_thr_word = (wr_data[15:0] & wr_mask) | (thr_word & ~wr_mask);
    wire [15:0] next_gain = (wr_data[15:0] & wr_mask) | (echo_gain & ~wr_mask);

    always_ff @(posedge CLK_SYS or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= ~have_aw & ~S_AXI_BVALID & ~do_write;
            S_AXI_WREADY <= ~have_w & ~S_AXI_BVALID & ~do_write;
            if (aw_fire) begin
                aw_addr <= S_AXI_AWADDR;
            end
            if (w_fire) begin
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            aw_held <= have_aw & ~do_write;
            w_held <= have_w & ~do_write;
            if (do_write) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tx_test_pattern_select <= TEST_SEL_RESET;
            cr_threshold <= CR_THRESHOLD_RESET;
            echo_gain <= ECHO_GAIN_RESET;
        end else begin
            if (wr_test) begin
                tx_test_pattern_select <= next_test_word[TEST_SEL_MSB:TEST_SEL_LSB];
            end
            if (wr_thr) begin
                cr_threshold <= next_thr_word[CR_THRESHOLD_W-1:0];
            end
            if (wr_gain) begin
                echo_gain <= next_gain;
            end
        end
    end

    // Read channel
    wire ar_fire = S_AXI_ARVALID & S_AXI_ARREADY;
    wire [15:0] rd_idx = word_index(S_AXI_ARADDR);
    wire [15:0] ability_word = {2'b00, 1'b1, high_level_tx_ability, 1'b1, 1'b0, 10'h000};
    wire [15:0] link_word = {6'h00, latched_low[3], live_ok[3], latched_low[2], live_ok[2],
        latched_low[1], live_ok[1], 2'b00, latched_low[0], live_ok[0]};
    wire [15:0] state_word = {11'h000, high_level_tx_ability, live_ok};
    wire rd_link = ar_fire & (rd_idx == IDX_LINK_STATUS);
    wire rd_known = (rd_idx == IDX_ABILITY) | (rd_idx == IDX_TEST_MODE) | (rd_idx == IDX_CR_THRESHOLD)
        | (rd_idx == IDX_ECHO_GAIN) | (rd_idx == IDX_LINK_STATUS) | (rd_idx == IDX_MSE)
        | (rd_idx == IDX_TEST_STATE);
    wire [15:0] rd_word = (rd_idx == IDX_ABILITY) ? ability_word :
        (rd_idx == IDX_TEST_MODE) ? test_word :
        (rd_idx == IDX_CR_THRESHOLD) ? thr_word :
        (rd_idx == IDX_ECHO_GAIN) ? echo_gain :
        (rd_idx == IDX_LINK_STATUS) ? link_word :
        (rd_idx == IDX_MSE) ? mse_value :
        (rd_idx == IDX_TEST_STATE) ? state_word : 16'h0000;

    always_ff @(posedge CLK_SYS or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= ~S_AXI_RVALID & ~ar_fire;
            if (ar_fire) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= {16'h0000, rd_word};
                S_AXI_RRESP <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // Latch-low: a false live condition beats the read clear, so no drop is lost.
    // Flags stay zero until the live bit has been seen high once after reset.
    wire [3:0] next_live_seen = live_seen | live_ok;
    // Per flag: only its own live bit can drop it, never a neighbour's
    wire [3:0] next_latched_low = live_ok & (
        {4{rd_link}} | latched_low | ~live_seen);
    always_ff @(posedge CLK_SYS or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            latched_low <= 4'h0;
            live_seen <= 4'h0;
            mse_value <= MSE_RESET;
        end else begin
            latched_low <= next_latched_low;
            live_seen <= next_live_seen;
            mse_value <= MSE_IN;
        end
    end

    // Reserved codes decode to no pattern, so transmit stays normal
    logic pat_override;
    logic [1:0] pat_symbol;
    logic pat_master;
    tlpma_pattern u_pattern (
        .clk(CLK_SYS),
        .rst_n(rst_sync_n),
        .mode(tx_test_pattern_select),
        .override(pat_override),
        .symbol(pat_symbol),
        .force_master(pat_master)
    );

    always_ff @(posedge CLK_SYS or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            TX_TEST_OVERRIDE <= 1'b0;
            TX_TEST_SYMBOL <= 2'h0;
            TX_FORCE_MASTER <= 1'b0;
            CR_OFFSET_THRESHOLD <= CR_THRESHOLD_RESET;
            ECHO_ACQ_GAIN <= ECHO_GAIN_RESET;
        end else begin
            TX_TEST_OVERRIDE <= pat_override;
            TX_TEST_SYMBOL <= pat_symbol;
            TX_FORCE_MASTER <= pat_master;
            CR_OFFSET_THRESHOLD <= cr_threshold;
            ECHO_ACQ_GAIN <= echo_gain;
        end
    end
endmodule : tlpma_regs

// ### hdl/tlpma_pkg.sv
// Package for the PMA status and test register slice.
// Assumes a 32-bit AXI4-Lite bus; registers sit in the low 16 bits of each word.
package tlpma_pkg;
    localparam int ADDR_W = 18;
    // Printed offsets are not all multiples of four: index, byte address is four times it
    localparam logic [15:0] IDX_ABILITY = 16'h08F7;
    localparam logic [15:0] IDX_TEST_MODE = 16'h08F8;
    localparam logic [15:0] IDX_CR_THRESHOLD = 16'h8015;
    localparam logic [15:0] IDX_ECHO_GAIN = 16'h81E7;
    localparam logic [15:0] IDX_LINK_STATUS = 16'h8302;
    localparam logic [15:0] IDX_MSE = 16'h830B;
    // Register of own choosing: live link inputs mirror and strap view
    localparam logic [15:0] IDX_TEST_STATE = 16'h9000;
    localparam logic [15:0] ABILITY_RESET = 16'h2800;
    localparam int LOOPBACK_ABILITY_BIT = 13;
    localparam int HIGH_LEVEL_TX_ABILITY_BIT = 12;
    localparam int SOFT_POWERDOWN_ABILITY_BIT = 11;
    localparam int ENERGY_EFFICIENT_ABILITY_BIT = 10;
    localparam int TEST_SEL_MSB = 15;
    localparam int TEST_SEL_LSB = 13;
    localparam logic [2:0] TEST_SEL_RESET = 3'h0;
    localparam int CR_THRESHOLD_W = 11;
    localparam logic [10:0] CR_THRESHOLD_RESET = 11'h008;
    localparam logic [15:0] ECHO_GAIN_RESET = 16'h0400;
    localparam logic [15:0] MSE_RESET = 16'h0000;
    localparam int LINK_OK_BIT = 0;
    localparam int DESCRAMBLER_OK_BIT = 4;
    localparam int LOCAL_RECEIVER_OK_BIT = 6;
    localparam int REMOTE_RECEIVER_OK_BIT = 8;
    localparam int DROOP_RUN_LEN = 10;
    localparam logic [3:0] DROOP_LAST = 4'h9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        TLPMA_NORMAL = 3'b000,
        TLPMA_ALTERNATE = 3'b001,
        TLPMA_DROOP = 3'b010,
        TLPMA_IDLE_MASTER = 3'b011
    } tlpma_test_mode_t;
    // Transmit symbol: 2'b01 is +1, 2'b11 is -1, 2'b00 is zero
    localparam logic [1:0] SYM_PLUS = 2'h1;
    localparam logic [1:0] SYM_MINUS = 2'h3;
endpackage : tlpma_pkg

// ### hdl/tlpma_pattern.sv
// Transmit test-pattern generator, one symbol per clock.
// Assumes the transmit path samples the symbol while override is high.
`timescale 1ns/10ps
module tlpma_pattern (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] mode,
    output logic override,
    output logic [1:0] symbol,
    output logic force_master
);
    import tlpma_pkg::*;
    logic [3:0] run_count;
    logic phase;
    wire is_alt = (mode == TLPMA_ALTERNATE);
    wire is_droop = (mode == TLPMA_DROOP);
    wire run_end = (run_count == DROOP_LAST);
    wire [3:0] next_run_count = (!is_droop || run_end) ? 4'h0 : run_count + 4'h1;
    wire next_phase = is_alt ? ~phase : (is_droop ? (run_end ? ~phase : phase) : 1'b0);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_count <= 4'h0;
            phase <= 1'b0;
            override <= 1'b0;
            symbol <= 2'h0;
            force_master <= 1'b0;
        end else begin
            run_count <= next_run_count;
            phase <= next_phase;
            override <= is_alt | is_droop;
            symbol <= (is_alt | is_droop) ? (phase ? SYM_MINUS : SYM_PLUS) : 2'h0;
            force_master <= (mode == TLPMA_IDLE_MASTER);
        end
    end
endmodule : tlpma_pattern

// ### bench/tlpma_link_model.sv
// Remote end model: live link indications and the MSE reading.
// Assumes the bench sets the targets; outputs move just after a clock edge.
`timescale 1ns/10ps
module tlpma_link_model (
    input wire logic clk,
    input wire logic [3:0] want,
    input wire logic [15:0] mse_want,
    output logic remote_ok = 1'h0,
    output logic local_ok = 1'h0,
    output logic descr_ok = 1'h0,
    output logic link_ok = 1'h0,
    output logic [15:0] mse = 16'h0
);
    // Registered so an indication never changes on the sampling edge
    always @(posedge clk) begin
        {remote_ok, local_ok, descr_ok, link_ok} <= want;
        mse <= mse_want;
    end
endmodule : tlpma_link_model

// ### bench/tlpma_regs_chk.sv
// Checker for the PMA register slice, top-level ports only.
// Assumes the strap input moves only while reset is held.
`timescale 1ns/10ps
module tlpma_chk (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [tlpma_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic HIGH_LEVEL_TX_STRAP,
    input wire logic REMOTE_RECEIVER_OK,
    input wire logic LOCAL_RECEIVER_OK,
    input wire logic DESCRAMBLER_OK,
    input wire logic LINK_OK,
    input wire logic [15:0] MSE_IN,
    input wire logic TX_TEST_OVERRIDE,
    input wire logic [1:0] TX_TEST_SYMBOL,
    input wire logic TX_FORCE_MASTER
);
    import tlpma_pkg::*;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    wire logic take = S_AXI_ARVALID && S_AXI_ARREADY;
    wire logic ab = take && S_AXI_ARADDR == {IDX_ABILITY, 2'h0};
    wire logic ls = take && S_AXI_ARADDR == {IDX_LINK_STATUS, 2'h0};
    wire logic ms = take && S_AXI_ARADDR == {IDX_MSE, 2'h0};
    a_ability_word: assert property (
        ab |=> S_AXI_RDATA[15:0] == {3'h1, $past(HIGH_LEVEL_TX_STRAP), 12'h800}) else $error("ability word wrong");
    // A flag may read one only if live was high the edge before the take
    a_remote_flag: assert property (
        ls |=> S_AXI_RDATA[9:8] == {S_AXI_RDATA[9] & $past(REMOTE_RECEIVER_OK, 2), $past(REMOTE_RECEIVER_OK)})
        else $error("remote receiver bits wrong");
    a_local_flag: assert property (
        ls |=> S_AXI_RDATA[7:6] == {S_AXI_RDATA[7] & $past(LOCAL_RECEIVER_OK, 2), $past(LOCAL_RECEIVER_OK)})
        else $error("local receiver bits wrong");
    a_descr_flag: assert property (
        ls |=> S_AXI_RDATA[5:4] == {S_AXI_RDATA[5] & $past(DESCRAMBLER_OK, 2), $past(DESCRAMBLER_OK)})
        else $error("descrambler bits wrong");
    a_link_flag: assert property (
        ls |=> S_AXI_RDATA[1:0] == {S_AXI_RDATA[1] & $past(LINK_OK, 2), $past(LINK_OK)}
        && S_AXI_RDATA[3:2] == 2'h0 && S_AXI_RDATA[15:10] == 6'h00) else $error("link bits wrong");
    a_mse_value: assert property (
        ms && $stable(MSE_IN) |=> S_AXI_RDATA[15:0] == $past(MSE_IN)) else $error("mse value wrong");
    a_symbol_legal: assert property (
        TX_TEST_OVERRIDE |-> TX_TEST_SYMBOL == SYM_PLUS || TX_TEST_SYMBOL == SYM_MINUS) else $error("bad symbol");
    a_master_alone: assert property (
        TX_FORCE_MASTER |-> !TX_TEST_OVERRIDE && TX_TEST_SYMBOL == 2'h0) else $error("master with pattern");
endmodule : tlpma_chk
bind tlpma_regs tlpma_chk u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .HIGH_LEVEL_TX_STRAP(HIGH_LEVEL_TX_STRAP), .REMOTE_RECEIVER_OK(REMOTE_RECEIVER_OK),
    .LOCAL_RECEIVER_OK(LOCAL_RECEIVER_OK), .DESCRAMBLER_OK(DESCRAMBLER_OK), .LINK_OK(LINK_OK), .MSE_IN(MSE_IN),
    .TX_TEST_OVERRIDE(TX_TEST_OVERRIDE), .TX_TEST_SYMBOL(TX_TEST_SYMBOL), .TX_FORCE_MASTER(TX_FORCE_MASTER));

// ### bench/tb.sv
// Directed bench for the PMA register slice over AXI4-Lite.
// Assumes the link model stands in for the remote end of the cable.
`timescale 1ns/10ps
module tb;
    import tlpma_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic strap = 1'h1;
    logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    logic [17:0] awa = 18'h0, ara = 18'h0;
    logic [31:0] wd = 32'h0;
    logic [3:0] want = 4'h0;
    logic [15:0] msew = 16'h0;
    wire awr, wrd, bv, arr, rv, rem, loc, dsc, lnk, ovr, fm;
    wire [1:0] br, rr, sym;
    wire [31:0] rdat;
    wire [15:0] mse, gain;
    wire [10:0] thr;
    int n_fail = 0;
    int n_checks = 0;
    logic [3:0] pw [8] = '{4'hF, 4'h7, 4'hF, 4'hB, 4'hD, 4'hE, 4'hF, 4'hF};
    logic [3:0] qw [8] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hE, 4'hF, 4'hF};
    logic [15:0] lx [8] = '{16'h03F3, 16'h01F3, 16'h03F3, 16'h0373, 16'h03D3, 16'h03F0, 16'h03F1, 16'h03F3};
    tlpma_regs uut (.CLK_SYS(clk), .RST_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .HIGH_LEVEL_TX_STRAP(strap),
        .REMOTE_RECEIVER_OK(rem), .LOCAL_RECEIVER_OK(loc), .DESCRAMBLER_OK(dsc), .LINK_OK(lnk), .MSE_IN(mse),
        .TX_TEST_OVERRIDE(ovr), .TX_TEST_SYMBOL(sym), .TX_FORCE_MASTER(fm), .CR_OFFSET_THRESHOLD(thr),
        .ECHO_ACQ_GAIN(gain));
    tlpma_link_model u_link (.clk(clk), .want(want), .mse_want(msew), .remote_ok(rem), .local_ok(loc),
        .descr_ok(dsc), .link_ok(lnk), .mse(mse));
    initial forever #20 clk = ~clk;
    task chk(input string nm, input logic [33:0] exp, input logic [33:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Address and data offered together, each dropped once taken
    task wr(input logic [15:0] ix, input logic [15:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'h0;
        w = 1'h0;
        @(posedge clk);
        awa <= {ix, 2'h0};
        wd <= {16'h0, d};
        awv <= 1'h1;
        wv <= 1'h1;
        bry <= 1'h1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (awv && awr) begin
                aw = 1'h1;
                awv <= 1'h0;
            end
            if (wv && wrd) begin
                w = 1'h1;
                wv <= 1'h0;
            end
        end
        while (bv !== 1'h1) @(posedge clk);
        bry <= 1'h0;
        chk("bresp", er, br);
    endtask : wr
    task rc(input string nm, input logic [15:0] ix, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        ara <= {ix, 2'h0};
        arv <= 1'h1;
        rry <= 1'h1;
        do @(posedge clk); while (arr !== 1'h1);
        arv <= 1'h0;
        do @(posedge clk); while (rv !== 1'h1);
        rry <= 1'h0;
        chk(nm, {er, exp}, {rr, rdat});
    endtask : rc
    task pat(input logic [2:0] m);
        logic [1:0] prev;
        logic pm;
        int run;
        int seen;
        pm = (m == 3'h1) || (m == 3'h2);
        prev = sym;
        run = 0;
        seen = 0;
        repeat (41) begin
            @(posedge clk);
            if (sym !== prev && seen > 0) chk("run", (m == 3'h1) ? 1 : DROOP_RUN_LEN, run);
            if (sym !== prev) seen++;
            run = (sym !== prev) ? 1 : run + 1;
            prev = sym;
        end
        chk("mode", {m == 3'h3, pm, pm, !pm}, {fm, ovr, seen > 0, sym == 2'h0});
    endtask : pat
    task close_out;
        if (n_fail == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        close_out;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge clk);
        rc("ability", IDX_ABILITY, 32'h3800, RESP_OKAY);
        rc("testmode", IDX_TEST_MODE, 32'h0, RESP_OKAY);
        rc("thresh", IDX_CR_THRESHOLD, 32'h8, RESP_OKAY);
        rc("gain", IDX_ECHO_GAIN, 32'h400, RESP_OKAY);
        rc("link", IDX_LINK_STATUS, 32'h0, RESP_OKAY);
        rc("mse", IDX_MSE, 32'h0, RESP_OKAY);
        chk("outs", {11'h008, 16'h0400}, {thr, gain});
        wr(IDX_CR_THRESHOLD, 16'hFFFF, RESP_OKAY);
        rc("thresh", IDX_CR_THRESHOLD, 32'h7FF, RESP_OKAY);
        wr(IDX_ECHO_GAIN, 16'hA5C3, RESP_OKAY);
        rc("gain", IDX_ECHO_GAIN, 32'hA5C3, RESP_OKAY);
        chk("outs", {11'h7FF, 16'hA5C3}, {thr, gain});
        wr(IDX_ABILITY, 16'h0000, RESP_OKAY);
        rc("ability", IDX_ABILITY, 32'h3800, RESP_OKAY);
        msew <= 16'h1234;
        wr(IDX_MSE, 16'h0000, RESP_OKAY);
        rc("mse", IDX_MSE, 32'h1234, RESP_OKAY);
        wr(16'h08F9, 16'h5555, RESP_SLVERR);
        rc("unmapped", 16'h08F9, 32'h0, RESP_SLVERR);
        for (int m = 0; m < 8; m++) begin
            wr(IDX_TEST_MODE, {m[2:0], 13'h1FFF}, RESP_OKAY);
            repeat (3) @(posedge clk);
            if (m < 4) rc("testmode", IDX_TEST_MODE, {16'h0, m[2:0], 13'h0}, RESP_OKAY);
            pat(m[2:0]);
        end
        // Each step drives the live word pw, then reads with the live word qw
        for (int i = 0; i < 8; i++) begin
            want <= pw[i];
            repeat (3) @(posedge clk);
            want <= qw[i];
            repeat (3) @(posedge clk);
            rc("link", IDX_LINK_STATUS, {16'h0, lx[i]}, RESP_OKAY);
        end
        rc("state", IDX_TEST_STATE, 32'h1F, RESP_OKAY);
        want <= 4'h0;
        strap <= 1'h0;
        rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge clk);
        rc("ability", IDX_ABILITY, 32'h2800, RESP_OKAY);
        rc("link", IDX_LINK_STATUS, 32'h0, RESP_OKAY);
        rc("thresh", IDX_CR_THRESHOLD, 32'h8, RESP_OKAY);
        close_out;
    end
endmodule : tb
